/* File: hdl/midi_consts.vh */
`ifndef MIDI_CONSTS_VH
`define MIDI_CONSTS_VH

// ****************************************************
// clock and serial timing
// ****************************************************
`define CLK_HZ          125000000
`define BIT_RATE_HZ     31250
// cycles per serial bit, 4000 at 125 MHz
`define BIT_CYCLES      12'hFA0
`define HALF_BIT_CYCLES 12'h7D0
`define FRAME_BITS      4'hA
`define DATA_BITS       3'h7

// ****************************************************
// host port offsets from the base address
// ****************************************************
`define DATA_OFS        16'h0000
`define CMD_OFS         16'h0001

// ****************************************************
// command codes and fixed bytes
// ****************************************************
`define CMD_RESET       8'hFF
`define CMD_UART        8'h3F
`define ACK_BYTE        8'hFE
`define STAT_RSVD       6'h3F
`define STAT_RXE_BIT    7
`define STAT_TXF_BIT    6

// ****************************************************
// fifo geometry and receive trigger levels
// ****************************************************
`define DATA_W          8
`define FIFO_DEPTH      16
`define FIFO_AW         4
`define TRIG_LVL0       5'h01
`define TRIG_LVL1       5'h04
`define TRIG_LVL2       5'h08
`define TRIG_LVL3       5'h0E

// ****************************************************
// reset values
// ****************************************************
`define LINE_IDLE       1'b1
`define RDATA_RST       8'h00

`endif

/* File: hdl/byte_fifo.v */
`timescale 1ns/100ps
`default_nettype none
`include "midi_consts.vh"

module byte_fifo (
  input  wire                 clk,     // device clock
  input  wire                 resetn,  // async reset, active low
  input  wire                 clr,     // synchronous flush
  input  wire                 wr_en,   // push request
  input  wire [`DATA_W-1:0]   wr_data, // byte to push
  input  wire                 rd_en,   // pop request
  output wire [`DATA_W-1:0]   rd_data, // head byte
  output wire                 full,    // no room left
  output wire                 empty,   // nothing stored
  output wire [`FIFO_AW:0]    count    // bytes stored
);

  // ****************************************************
  // storage and pointers
  // ****************************************************
  reg [`DATA_W-1:0]  mem_ff [0:`FIFO_DEPTH-1]; // byte store
  reg [`FIFO_AW-1:0] wptr_ff;                  // write index
  reg [`FIFO_AW-1:0] rptr_ff;                  // read index
  reg [`FIFO_AW:0]   count_ff;                 // fill level

  // push on full and pop on empty are dropped, never wrap
  wire do_wr = wr_en & ~full;
  wire do_rd = rd_en & ~empty;

  assign full    = (count_ff == `FIFO_DEPTH);
  assign empty   = (count_ff == {(`FIFO_AW+1){1'b0}});
  assign count   = count_ff;
  assign rd_data = mem_ff[rptr_ff];

  // store is not reset, only pointers and fill level carry state
  always @(posedge clk) begin
    if (do_wr) begin
      mem_ff[wptr_ff] <= wr_data;
    end
  end

  // pointer and level update, flush wins
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wptr_ff  <= {`FIFO_AW{1'b0}};
      rptr_ff  <= {`FIFO_AW{1'b0}};
      count_ff <= {(`FIFO_AW+1){1'b0}};
    end else if (clr) begin
      wptr_ff  <= {`FIFO_AW{1'b0}};
      rptr_ff  <= {`FIFO_AW{1'b0}};
      count_ff <= {(`FIFO_AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (do_rd) begin
        rptr_ff <= rptr_ff + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_ff <= count_ff + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: hdl/serial_rx.v */
`timescale 1ns/100ps
`default_nettype none
`include "midi_consts.vh"

module serial_rx (
  input  wire               clk,        // device clock
  input  wire               resetn,     // async reset, active low
  input  wire               clr,        // abort any frame
  input  wire               line_in,    // raw serial pin
  output reg  [`DATA_W-1:0] byte_ff,    // last good byte
  output reg                byte_vld_ff // one-cycle pulse
);

  // ****************************************************
  // states and timing
  // ****************************************************
  localparam [1:0] RX_IDLE  = 2'h0;
  localparam [1:0] RX_START = 2'h1;
  localparam [1:0] RX_DATA  = 2'h2;
  localparam [1:0] RX_STOP  = 2'h3;
  localparam [11:0] BIT_LAST  = `BIT_CYCLES - 1'b1;
  localparam [11:0] HALF_LAST = `HALF_BIT_CYCLES - 1'b1;

  reg               sync1_ff;  // first synchroniser stage
  reg               sync2_ff;  // second synchroniser stage
  reg [1:0]         state_ff;  // frame state
  reg [11:0]        cnt_ff;    // cycles within bit
  reg [2:0]         bitn_ff;   // data bit index
  reg [`DATA_W-1:0] shift_ff;  // assembling byte

  // pin passes two flops before any decision
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_ff <= `LINE_IDLE;
      sync2_ff <= `LINE_IDLE;
    end else begin
      sync1_ff <= line_in;
      sync2_ff <= sync1_ff;
    end
  end

  // frame walker, samples at bit centres
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff    <= RX_IDLE;
      cnt_ff      <= 12'h000;
      bitn_ff     <= 3'h0;
      shift_ff    <= 8'h00;
      byte_ff     <= 8'h00;
      byte_vld_ff <= 1'b0;
    end else begin
      byte_vld_ff <= 1'b0;
      cnt_ff      <= cnt_ff + 1'b1;
      if (clr) begin
        state_ff <= RX_IDLE;
      end else begin
        case (state_ff)
          RX_IDLE: begin
            cnt_ff <= 12'h000;
            if (!sync2_ff) begin // falling edge, line idles high RULE20
              state_ff <= RX_START;
            end
          end
          RX_START: begin
            if (cnt_ff == HALF_LAST) begin // centre of start bit RULE20
              cnt_ff  <= 12'h000;
              bitn_ff <= 3'h0;
              // a glitch shorter than half a bit is ignored
              state_ff <= sync2_ff ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (cnt_ff == BIT_LAST) begin
              cnt_ff   <= 12'h000;
              shift_ff <= {sync2_ff, shift_ff[7:1]}; // lsb first RULE20
              bitn_ff  <= bitn_ff + 1'b1;
              if (bitn_ff == `DATA_BITS) begin // eight data bits RULE1
                state_ff <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (cnt_ff == BIT_LAST) begin
              state_ff <= RX_IDLE;
              // single stop bit, no parity; bad stop drops byte RULE1
              if (sync2_ff) begin
                byte_ff     <= shift_ff;
                byte_vld_ff <= 1'b1;
              end
            end
          end
          default: begin
            state_ff <= RX_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: hdl/midi_uart_emulator.v */
// Overview of operation
// RULE1: frame is start, eight data, one stop
// RULE2: bit rate fixed at 31.25 kilobaud
// RULE3: base is data port, base+1 command/status
// RULE4: one interrupt, programmable base and level
// RULE5: separate 16-byte transmit and receive fifos
// RULE6: offset one: write command, read status
// RULE7: status bit 7 set when receive empty
// RULE8: status bit 6 set when transmit full
// RULE9: status bits 5..0 always read 3Fh
// RULE10: only commands FFh reset and 3Fh uart
// RULE11: reset starts in acknowledge-only mode
// RULE12: acknowledge mode data reads return FEh
// RULE13: acknowledge mode data writes are discarded
// RULE14: 3Fh enters uart, loads FEh, interrupts
// RULE15: acknowledge mode FFh reinitialises, others ignored
// RULE16: uart data read pops receive fifo
// RULE17: receive interrupt follows fifo trigger level
// RULE18: uart data writes queue and transmit in order
// RULE19: uart mode FFh returns to acknowledge mode
// RULE20: lsb first, idle high, centre sampling
`timescale 1ns/100ps
`default_nettype none
`include "midi_consts.vh"

module midi_uart_emulator (
  input  wire        clk,            // device clock, 125 MHz
  input  wire        resetn,         // async reset, active low
  input  wire [15:0] base_addr,      // programmable i/o base
  input  wire [3:0]  irq_sel,        // programmable irq level
  input  wire [1:0]  rx_trig_sel,    // receive trigger select
  input  wire [15:0] io_addr,        // host i/o address
  input  wire        io_wr,          // host write strobe
  input  wire        io_rd,          // host read strobe
  input  wire [7:0]  io_wdata,       // host write data
  output reg  [7:0]  io_rdata_ff,    // host read data
  output reg         io_rvalid_ff,   // read data valid pulse
  output reg  [15:0] irq_lines_ff,   // one-hot interrupt lines
  input  wire        serial_in_line, // serial receive pin
  output reg         serial_out_line // serial transmit pin
);

  // ****************************************************
  // local constants
  // ****************************************************
  localparam [0:0] TX_IDLE = 1'b0;                // no frame in flight
  localparam [0:0] TX_SEND = 1'b1;                // frame shifting
  localparam [11:0] BIT_LAST = `BIT_CYCLES - 1'b1; // bit period end
  localparam [9:0]  SHIFT_IDLE = 10'h3FF;         // all stop level

  // ****************************************************
  // helper functions
  // ****************************************************

  // match against base plus offset, wraps inside 16 bits
  function addr_hit;
    input [15:0] addr;
    input [15:0] base;
    input [15:0] ofs;
    reg   [15:0] sum;
    begin
      sum      = base + ofs;
      addr_hit = (addr == sum);
    end
  endfunction

  // map the two select bits onto a fill threshold
  function [4:0] trig_level;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    trig_level = `TRIG_LVL0;
        2'h1:    trig_level = `TRIG_LVL1;
        2'h2:    trig_level = `TRIG_LVL2;
        default: trig_level = `TRIG_LVL3;
      endcase
    end
  endfunction

  // ****************************************************
  // state
  // ****************************************************
  reg        uart_mode_ff; // 0 acknowledge-only, 1 uart
  reg        ack_irq_ff;   // interrupt from acknowledge load
  reg        tx_state_ff;  // transmitter state
  reg [11:0] tx_cnt_ff;    // cycles within bit
  reg [3:0]  tx_bitn_ff;   // bits sent in frame
  reg [9:0]  tx_shift_ff;  // frame being shifted

  // ****************************************************
  // address decode
  // ****************************************************

  // two consecutive addresses from the programmable base
  wire hit_data = addr_hit(io_addr, base_addr, `DATA_OFS); // RULE3 RULE4
  wire hit_cmd  = addr_hit(io_addr, base_addr, `CMD_OFS);  // RULE3

  wire data_wr  = io_wr & hit_data;
  wire data_rd  = io_rd & hit_data;
  wire cmd_wr   = io_wr & hit_cmd;   // write side of offset one RULE6
  wire stat_rd  = io_rd & hit_cmd;   // read side of offset one RULE6

  // only two codes decode, all others fall through RULE10
  wire cmd_reset = cmd_wr & (io_wdata == `CMD_RESET);
  wire cmd_uart  = cmd_wr & (io_wdata == `CMD_UART);

  // 3Fh only acts while still in acknowledge mode RULE14
  wire ack_load  = cmd_uart & ~uart_mode_ff;

  // FFh flushes everything in either mode RULE15 RULE19
  wire soft_clr  = cmd_reset;

  // ****************************************************
  // receive path
  // ****************************************************
  wire [7:0] rx_byte;   // byte from the deserialiser
  wire       rx_vld;    // byte strobe
  wire [7:0] rxf_head;  // receive fifo head
  wire       rxf_full;  // receive fifo full
  wire       rxf_empty; // receive fifo empty
  wire [4:0] rxf_count; // receive fifo level

  serial_rx u_rx (
    .clk         (clk),
    .resetn      (resetn),
    .clr         (soft_clr),
    .line_in     (serial_in_line),
    .byte_ff     (rx_byte),
    .byte_vld_ff (rx_vld)
  );

  // line bytes are kept only in uart mode; the acknowledge
  // byte shares the push port since the two never coincide
  wire       rxf_push = ack_load | (rx_vld & uart_mode_ff);
  wire [7:0] rxf_din  = ack_load ? `ACK_BYTE : rx_byte; // RULE14
  // each uart data read takes the next byte RULE16
  wire       rxf_pop  = data_rd & uart_mode_ff;

  // a byte arriving on a full fifo is lost, there is no
  // overrun flag in this port
  byte_fifo u_rx_fifo ( // 16-byte receive store RULE5
    .clk     (clk),
    .resetn  (resetn),
    .clr     (soft_clr),
    .wr_en   (rxf_push),
    .wr_data (rxf_din),
    .rd_en   (rxf_pop),
    .rd_data (rxf_head),
    .full    (rxf_full),
    .empty   (rxf_empty),
    .count   (rxf_count)
  );

  // ****************************************************
  // transmit path
  // ****************************************************
  wire [7:0] txf_head;  // transmit fifo head
  wire       txf_full;  // transmit fifo full
  wire       txf_empty; // transmit fifo empty
  wire       txf_pop;   // start of a new frame

  // data writes are dropped outside uart mode RULE13
  wire txf_push = data_wr & uart_mode_ff; // RULE18
  assign txf_pop = (tx_state_ff == TX_IDLE) & ~txf_empty & ~soft_clr;

  byte_fifo u_tx_fifo ( // 16-byte transmit store RULE5
    .clk     (clk),
    .resetn  (resetn),
    .clr     (soft_clr),
    .wr_en   (txf_push),
    .wr_data (io_wdata),
    .rd_en   (txf_pop),
    .rd_data (txf_head),
    .full    (txf_full),
    .empty   (txf_empty),
    .count   ()
  );

  // serialiser: fixed divider, nothing host-visible RULE2
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_state_ff <= TX_IDLE;
      tx_cnt_ff   <= 12'h000;
      tx_bitn_ff  <= 4'h0;
      tx_shift_ff <= SHIFT_IDLE;
    end else if (soft_clr) begin
      // a frame cut short here may look like a break
      tx_state_ff <= TX_IDLE;
      tx_cnt_ff   <= 12'h000;
      tx_bitn_ff  <= 4'h0;
      tx_shift_ff <= SHIFT_IDLE;
    end else begin
      case (tx_state_ff)
        TX_IDLE: begin
          if (txf_pop) begin // bytes leave in fifo order RULE18
            // stop, data, start; shifted out lsb first RULE1 RULE20
            tx_shift_ff <= {1'b1, txf_head, 1'b0};
            tx_cnt_ff   <= 12'h000;
            tx_bitn_ff  <= 4'h0;
            tx_state_ff <= TX_SEND;
          end
        end
        TX_SEND: begin
          tx_cnt_ff <= tx_cnt_ff + 1'b1;
          if (tx_cnt_ff == BIT_LAST) begin // one bit time RULE2
            tx_cnt_ff   <= 12'h000;
            tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
            tx_bitn_ff  <= tx_bitn_ff + 1'b1;
            if (tx_bitn_ff == `FRAME_BITS - 1'b1) begin // RULE1
              tx_state_ff <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_state_ff <= TX_IDLE;
        end
      endcase
    end
  end

  // pin is registered; idle level is high RULE20
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serial_out_line <= `LINE_IDLE;
    end else if (tx_state_ff == TX_SEND) begin
      serial_out_line <= tx_shift_ff[0];
    end else begin
      serial_out_line <= `LINE_IDLE;
    end
  end

  // ****************************************************
  // mode control
  // ****************************************************

  // power-up lands in acknowledge-only mode RULE11
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      uart_mode_ff <= 1'b0;
    end else if (soft_clr) begin
      uart_mode_ff <= 1'b0; // back to initial condition RULE15 RULE19
    end else if (ack_load) begin
      uart_mode_ff <= 1'b1; // RULE14
    end
  end

  // acknowledge interrupt holds until the byte is read;
  // a new load in the same cycle as a read wins
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_irq_ff <= 1'b0;
    end else if (soft_clr) begin
      ack_irq_ff <= 1'b0;
    end else if (ack_load) begin
      ack_irq_ff <= 1'b1; // RULE14
    end else if (rxf_pop) begin
      ack_irq_ff <= 1'b0;
    end
  end

  // ****************************************************
  // status and read data
  // ****************************************************

  // acknowledge mode always holds its ack byte, so never
  // empty there; the flag tracks the fifo once in uart mode
  wire receive_empty_flag = uart_mode_ff & rxf_empty; // RULE7
  wire transmit_full_flag = uart_mode_ff & txf_full;  // RULE8

  wire [7:0] status_byte;
  assign status_byte[`STAT_RXE_BIT] = receive_empty_flag; // RULE7
  assign status_byte[`STAT_TXF_BIT] = transmit_full_flag; // RULE8
  assign status_byte[5:0]           = `STAT_RSVD;         // RULE9

  // read data is captured one cycle after the strobe
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      io_rdata_ff  <= `RDATA_RST;
      io_rvalid_ff <= 1'b0;
    end else begin
      io_rvalid_ff <= data_rd | stat_rd;
      if (stat_rd) begin
        io_rdata_ff <= status_byte; // RULE6
      end else if (data_rd) begin
        if (!uart_mode_ff) begin
          io_rdata_ff <= `ACK_BYTE; // RULE12
        end else begin
          // reading an empty fifo returns the stale byte at the read index
          io_rdata_ff <= rxf_head; // RULE16
        end
      end
    end
  end

  // ****************************************************
  // interrupt
  // ****************************************************

  // level interrupt: ack load, or fill at or above trigger
  wire rx_trig_hit = uart_mode_ff &
                     (rxf_count >= trig_level(rx_trig_sel)); // RULE17
  wire irq_req     = ack_irq_ff | rx_trig_hit;

  // routed onto the selected level only RULE4
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_lines_ff <= 16'h0000;
    end else if (irq_req) begin
      irq_lines_ff <= 16'h0001 << irq_sel;
    end else begin
      irq_lines_ff <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

/* File: tb/midi_uart_emulator_properties.sv */
`timescale 1ns/100ps
`default_nettype none
`include "midi_consts.vh"

module midi_uart_checker (
  input wire logic        clk,             // device clock
  input wire logic        resetn,          // async reset, active low
  input wire logic [15:0] base_addr,       // i/o base
  input wire logic [3:0]  irq_sel,         // irq level
  input wire logic [1:0]  rx_trig_sel,     // receive trigger
  input wire logic [15:0] io_addr,         // host address
  input wire logic        io_wr,           // write strobe
  input wire logic        io_rd,           // read strobe
  input wire logic [7:0]  io_wdata,        // write data
  input wire logic [7:0]  io_rdata_ff,     // read data
  input wire logic        io_rvalid_ff,    // read valid
  input wire logic [15:0] irq_lines_ff,    // interrupt lines
  input wire logic        serial_in_line,  // serial in
  input wire logic        serial_out_line  // serial out
);
  // ****************************************************
  // helper logic
  // ****************************************************
  localparam int bit_cyc = `BIT_CYCLES;  // cycles per bit
  logic [15:0] lo_cnt_ff;                // length of low run
  logic        abort_ff;                 // frame cut by soft reset
  wire         hit_data = io_addr == base_addr;
  wire         hit_cmd  = io_addr == base_addr + 16'h0001;
  wire         soft_rst = io_wr && hit_cmd && io_wdata == 8'hFF;

  // low run of a cut frame is excused
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lo_cnt_ff <= 16'h0000;
      abort_ff  <= 1'b0;
    end else begin
      lo_cnt_ff <= serial_out_line ? 16'h0000 : lo_cnt_ff + 16'h0001;
      abort_ff  <= soft_rst | (abort_ff & (serial_out_line |
                   (lo_cnt_ff != 16'h0000)));
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ****************************************************
  // assertions
  // ****************************************************
  rvalid_hit_a: assert property (io_rd && (hit_data || hit_cmd) |=>
    io_rvalid_ff) else $error("read of the port gave no valid");
  rvalid_miss_a: assert property (!(io_rd && (hit_data || hit_cmd))
    |=> !io_rvalid_ff) else $error("valid without a port read");
  status_rsvd_a: assert property (io_rd && hit_cmd |=>
    io_rdata_ff[5:0] == 6'h3F) else $error("status low bits wrong");
  rdata_hold_a: assert property (!io_rvalid_ff |->
    $stable(io_rdata_ff)) else $error("read data moved without read");
  irq_only_sel_a: assert property ((irq_lines_ff &
    ~(16'h0001 << $past(irq_sel))) == 16'h0000)
    else $error("interrupt on an unselected line");
  reset_quiet_a: assert property (soft_rst |-> ##2
    (serial_out_line && irq_lines_ff == 16'h0000) ##1 serial_out_line[*2])
    else $error("soft reset left line or irq active");
  frame_bits_a: assert property ($rose(serial_out_line) && !abort_ff
    |-> (lo_cnt_ff % bit_cyc == 0) && lo_cnt_ff <= 9 * bit_cyc)
    else $error("low run not a whole number of bits");
  ack_read_a: assert property (soft_rst ##1 (io_rd && hit_data)
    |=> io_rdata_ff == 8'hFE) else $error("ack byte missing");
  ack_status_a: assert property (soft_rst ##1 (io_rd && hit_cmd)
    |=> io_rdata_ff == 8'h3F) else $error("ack mode status wrong");

  // ****************************************************
  // covers
  // ****************************************************
  cover property (soft_rst ##1 (io_rd && hit_data));
  cover property ($rose(serial_out_line) && !abort_ff);
  cover property ($rose(irq_lines_ff != 16'h0000));
endmodule

bind midi_uart_emulator midi_uart_checker midi_uart_checker_inst (
  .clk(clk), .resetn(resetn), .base_addr(base_addr), .irq_sel(irq_sel),
  .rx_trig_sel(rx_trig_sel), .io_addr(io_addr), .io_wr(io_wr),
  .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff),
  .io_rvalid_ff(io_rvalid_ff), .irq_lines_ff(irq_lines_ff),
  .serial_in_line(serial_in_line), .serial_out_line(serial_out_line)
);
`default_nettype wire

/* File: tb/midi_instrument.sv */
`timescale 1ns/100ps
`default_nettype none
`include "midi_consts.vh"

module midi_instrument (
  input  wire logic clk,     // device clock
  input  wire logic rx_line, // hears the serial output
  output var  logic tx_line  // drives the serial input
);
  logic [7:0] got_q[$];      // bytes heard, in order
  logic [7:0] sh;            // receive shifter

  initial tx_line = 1'b1;    // idle high

  // one frame: start 0, data lsb first, stop 1
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      #1 tx_line = fr[i];
      repeat (`BIT_CYCLES - 1) @(posedge clk);
    end
  endtask

  // centre sampling; a bad stop bit drops the byte
  initial forever begin
    @(negedge rx_line);
    repeat (`HALF_BIT_CYCLES) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      repeat (`BIT_CYCLES) @(posedge clk);
      sh[k] = rx_line;
    end
    repeat (`BIT_CYCLES) @(posedge clk);
    if (rx_line) got_q.push_back(sh);
  end
endmodule
`default_nettype wire

/* File: tb/midi_uart_emulator_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "midi_consts.vh"

module midi_uart_emulator_tb;
  // ****************************************************
  // signals
  // ****************************************************
  logic        clk = 1'b0;            // device clock
  logic        resetn = 1'b0;         // reset, active low
  logic [15:0] base_addr = 16'h0330;  // port base
  logic [3:0]  irq_sel = 4'h5;        // irq level
  logic [1:0]  rx_trig_sel = 2'h0;    // trigger at one byte
  logic [15:0] io_addr = 16'h0000;    // host address
  logic        io_wr = 1'b0;          // write strobe
  logic        io_rd = 1'b0;          // read strobe
  logic [7:0]  io_wdata = 8'h00;      // write data
  wire  logic [7:0]  io_rdata_ff;     // read data
  wire  logic        io_rvalid_ff;    // read valid
  wire  logic [15:0] irq_lines_ff;    // interrupt lines
  wire  logic        serial_in_line;  // from the instrument
  wire  logic        serial_out_line; // to the instrument
  int          err_count = 0;         // mismatches
  int          tests_run = 0;         // comparisons

  always #4 clk = ~clk; // 125 MHz

  midi_uart_emulator midi_uart_emulator_inst (
    .clk(clk), .resetn(resetn), .base_addr(base_addr),
    .irq_sel(irq_sel), .rx_trig_sel(rx_trig_sel), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata_ff(io_rdata_ff), .io_rvalid_ff(io_rvalid_ff),
    .irq_lines_ff(irq_lines_ff), .serial_in_line(serial_in_line),
    .serial_out_line(serial_out_line));
  midi_instrument midi_instrument_inst (
    .clk(clk), .rx_line(serial_out_line), .tx_line(serial_in_line));

  // ****************************************************
  // tasks
  // ****************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe, then a gap cycle
  task automatic wr(input logic [15:0] ofs, input logic [7:0] d);
    @(posedge clk);
    #1 io_addr = base_addr + ofs;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clk);
    #1 io_wr = 1'b0;
  endtask

  // answer stands just after the taking edge
  task automatic rd(input logic [15:0] ofs, input logic v,
                    input logic [7:0] d);
    @(posedge clk);
    #1 io_addr = base_addr + ofs;
    io_rd = 1'b1;
    @(posedge clk);
    #1 io_rd = 1'b0;
    chk({15'h0000, io_rvalid_ff}, {15'h0000, v});
    if (v) chk({8'h00, io_rdata_ff}, {8'h00, d});
  endtask

  // soft reset, then a read on the very next cycle
  task automatic ffrd(input logic [15:0] ofs, input logic [7:0] d);
    @(posedge clk);
    #1 io_addr = base_addr + 16'h0001;
    io_wdata = 8'hFF;
    io_wr = 1'b1;
    @(posedge clk);
    #1 io_wr = 1'b0;
    io_addr = base_addr + ofs;
    io_rd = 1'b1;
    @(posedge clk);
    #1 io_rd = 1'b0;
    chk({8'h00, io_rdata_ff}, {8'h00, d});
  endtask

  task automatic conclude;
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // two frames each way take about 84000 cycles
  initial begin
    repeat (95000) @(posedge clk);
    err_count++;
    conclude();
  end

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    repeat (6) @(posedge clk);
    #1 resetn = 1'b1;
    rd(16'h0001, 1'b1, 8'h3F);
    rd(16'h0000, 1'b1, 8'hFE);
    rd(16'h0000, 1'b1, 8'hFE);
    rd(16'h0002, 1'b0, 8'h00);
    wr(16'h0000, 8'h00);
    wr(16'h0001, 8'h55);
    rd(16'h0001, 1'b1, 8'h3F);
    wr(16'h0001, 8'h3F);
    @(posedge clk);
    #1 chk(irq_lines_ff, 16'h0020);
    rd(16'h0001, 1'b1, 8'h3F);
    rd(16'h0000, 1'b1, 8'hFE);
    rd(16'h0001, 1'b1, 8'hBF);
    chk(irq_lines_ff, 16'h0000);
    // no dropped byte on the line
    repeat (16) begin
      @(posedge clk);
      #1 chk({15'h0000, serial_out_line}, 16'h0001);
    end
    wr(16'h0001, 8'h55);
    wr(16'h0001, 8'h3F);
    rd(16'h0001, 1'b1, 8'hBF);
    chk(irq_lines_ff, 16'h0000);
    irq_sel = 4'hA;
    fork
      begin
        midi_instrument_inst.send(8'h96);
        midi_instrument_inst.send(8'h0F);
      end
      begin
        wr(16'h0000, 8'hA5);
        wr(16'h0000, 8'h3C);
      end
    join
    repeat (`BIT_CYCLES) @(posedge clk);
    #1 chk(16'(midi_instrument_inst.got_q.size()), 16'h0002);
    chk({8'h00, midi_instrument_inst.got_q[0]}, 16'h00A5);
    chk({8'h00, midi_instrument_inst.got_q[1]}, 16'h003C);
    chk(irq_lines_ff, 16'h0400);
    for (int s = 1; s < 4; s++) begin
      rx_trig_sel = 2'(s);
      repeat (2) @(posedge clk);
      #1 chk(irq_lines_ff, 16'h0000);
    end
    rx_trig_sel = 2'h0;
    repeat (2) @(posedge clk);
    #1 chk(irq_lines_ff, 16'h0400);
    rd(16'h0000, 1'b1, 8'h96);
    rd(16'h0000, 1'b1, 8'h0F);
    rd(16'h0001, 1'b1, 8'hBF);
    chk(irq_lines_ff, 16'h0000);
    // one byte goes to the shifter, sixteen fill the queue
    repeat (16) wr(16'h0000, 8'h00);
    rd(16'h0001, 1'b1, 8'hBF);
    wr(16'h0000, 8'h00);
    rd(16'h0001, 1'b1, 8'hFF);
    base_addr = 16'hFFFF;
    ffrd(16'h0001, 8'h3F);
    ffrd(16'h0000, 8'hFE);
    conclude();
  end
endmodule
`default_nettype wire
